// ===== hw/dbsc_channel.sv
// DMA channel burst length, transfer count, width packing and protection control with its byte FIFO
`timescale 1ns/10ps
`default_nettype none
`include "dbsc_params.svh"

module dbsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } dbsc_fifo_s;
  dbsc_fifo_s q, n;
  logic push;
  logic pop;

  assign in_ready_o = q.cnt != FULL;
  assign out_valid_o = q.cnt != '0;
  assign out_data_o = q.mem[q.rd];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wr] = in_data_i;
      n.wr = q.wr + 1'b1;
    end
    if (pop) begin
      n.rd = q.rd + 1'b1;
    end
    n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= n;
    end
  end
endmodule

// Overview of operation
// - Each destination burst request moves the destination burst length worth of destination transfers, or fewer once the controller-flow count runs out.
// - Each source burst request moves the source burst length worth of source transfers, or fewer once the controller-flow count runs out.
// - The bus burst type driven on the bus never depends on the burst length fields.
// - Burst length codes 0 to 7 mean 1, 4, 8, 16, 32, 64, 128 and 256 transfers.
// - Writing the 12-bit count field sets the total transfers when the controller controls flow.
// - In controller flow the count falls by one per completed destination transfer and reads back what remains.
// - Width codes 0, 1, 2 mean byte, halfword and word; codes 3 to 7 are reserved.
// - Every transfer carries protection attributes from the protection field and the lock setting.
// - Protection bit 0 drives the privileged attribute bit 1.
// - Protection bit 1 drives the bufferable attribute bit 2.
// - Protection bit 2 drives the cacheable attribute bit 3.
// - Differing source and destination widths are packed and unpacked automatically.
module dbsc_channel (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic src_breq_i,
  input wire logic dst_breq_i,
  output logic src_rd_o,
  input wire logic [31:0] src_rdata_i,
  input wire logic src_rvalid_i,
  output logic dst_wr_o,
  output logic [31:0] dst_wdata_o,
  input wire logic dst_ready_i,
  output logic [2:0] src_size_o,
  output logic [2:0] dst_size_o,
  output logic [3:0] hprot_o,
  output logic hlock_o,
  output logic [2:0] hburst_o
);
  import dbsc_pkg::*;

  function automatic logic [8:0] burst_len(input logic [2:0] code);
    burst_len = (code == 3'h0) ? 9'h001 : (9'h002 << code);
  endfunction

  function automatic logic [2:0] width_bytes(input logic [2:0] code);
    unique case (code)
      3'h0: width_bytes = 3'h1;
      3'h1: width_bytes = 3'h2;
      3'h2: width_bytes = 3'h4;
      default: width_bytes = 3'h0;
    endcase
  endfunction

  function automatic logic [31:0] sel_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        old[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    sel_merge = old;
  endfunction

  dbsc_state_s q, n;
  logic bus_wr;
  logic wr_ctrl;
  logic wr_setup;
  logic ctl_flow;
  logic active;
  logic [2:0] sb;
  logic [2:0] db;
  logic [11:0] cnt;
  logic [31:0] setup_rd;
  logic [31:0] setup_wr;
  logic f_in_valid;
  logic f_in_ready;
  logic [7:0] f_in_data;
  logic f_out_valid;
  logic f_out_ready;
  logic [7:0] f_out_data;

  assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & q.ack;
  assign wr_ctrl = bus_wr && (wb_adr_i == `DBSC_CTRL_OFS);
  assign wr_setup = bus_wr && (wb_adr_i == `DBSC_SETUP_OFS);
  assign ctl_flow = q.flow <= `DBSC_FLOW_CTRL_MAX;
  assign sb = width_bytes(q.ctrl[`DBSC_SWID_HI:`DBSC_SWID_LO]);
  assign db = width_bytes(q.ctrl[`DBSC_DWID_HI:`DBSC_DWID_LO]);
  assign cnt = q.ctrl[`DBSC_CNT_HI:`DBSC_CNT_LO];
  assign active = f_out_valid | (q.dst != DST_IDLE);
  assign setup_wr = sel_merge(setup_rd, wb_dat_i, wb_sel_i);

  always_comb begin
    setup_rd = '0;
    setup_rd[`DBSC_EN_BIT] = q.en;
    setup_rd[`DBSC_FLOW_HI:`DBSC_FLOW_LO] = q.flow;
    setup_rd[`DBSC_LOCK_BIT] = q.lock;
    setup_rd[`DBSC_ACT_BIT] = active;
    setup_rd[`DBSC_HALT_BIT] = q.halt;
  end

  // Each source beat is split into bytes so any width pair meets in one byte-wide queue
  assign f_in_valid = q.sst == SRC_PUSH;
  assign f_in_data = q.sbuf[{q.sidx, 3'b000} +: 8];
  assign f_out_ready = q.dst == DST_GATHER;

  dbsc_fifo #(
    .WIDTH(`DBSC_FIFO_WIDTH),
    .DEPTH(`DBSC_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(f_in_valid),
    .in_ready_o(f_in_ready),
    .in_data_i(f_in_data),
    .out_valid_o(f_out_valid),
    .out_ready_i(f_out_ready),
    .out_data_o(f_out_data)
  );

  always_comb begin
    n = q;
    n.req_s1 = {dst_breq_i, src_breq_i};
    n.req_s2 = q.req_s1;
    n.ack = wb_cyc_i & wb_stb_i & ~q.ack;
    if (wb_adr_i == `DBSC_CTRL_OFS) begin
      n.rdat = q.ctrl;
    end else if (wb_adr_i == `DBSC_SETUP_OFS) begin
      n.rdat = setup_rd;
    end else begin
      n.rdat = '0;
    end
    unique case (q.sst)
      SRC_IDLE: begin
        if (q.en && !q.halt && q.req_s2[0] && (!ctl_flow || q.srem != '0)) begin
          n.sbcnt = burst_len(q.ctrl[`DBSC_SBSZ_HI:`DBSC_SBSZ_LO]);
          n.sst = SRC_READ;
        end
      end
      SRC_READ: begin
        if (src_rvalid_i) begin
          n.sbuf = src_rdata_i;
          n.sidx = 2'h0;
          n.sst = SRC_PUSH;
        end
      end
      SRC_PUSH: begin
        if (f_in_ready) begin
          n.sidx = q.sidx + 2'h1;
          if ({1'b0, q.sidx} == sb - 3'h1) begin
            n.sbcnt = q.sbcnt - 9'h001;
            n.srem = (q.srem > 14'(sb)) ? q.srem - 14'(sb) : 14'h0000;
            if (q.sbcnt == 9'h001 || (ctl_flow && q.srem <= 14'(sb))) begin
              n.sst = SRC_IDLE;
            end else begin
              n.sst = SRC_READ;
            end
          end
        end
      end
      default: n.sst = SRC_IDLE;
    endcase
    unique case (q.dst)
      DST_IDLE: begin
        if (q.en && q.req_s2[1] && (!ctl_flow || cnt != '0)) begin
          n.dbcnt = burst_len(q.ctrl[`DBSC_DBSZ_HI:`DBSC_DBSZ_LO]);
          n.didx = 2'h0;
          n.dst = DST_GATHER;
        end
      end
      DST_GATHER: begin
        if (f_out_valid) begin
          n.dbuf[{q.didx, 3'b000} +: 8] = f_out_data;
          n.didx = q.didx + 2'h1;
          if ({1'b0, q.didx} == db - 3'h1) begin
            n.dst = DST_WRITE;
          end
        end
      end
      DST_WRITE: begin
        if (dst_ready_i) begin
          n.dbcnt = q.dbcnt - 9'h001;
          n.didx = 2'h0;
          n.dbuf = '0;
          if (ctl_flow) begin
            n.ctrl[`DBSC_CNT_HI:`DBSC_CNT_LO] = cnt - 12'h001;
          end
          if (ctl_flow && cnt == 12'h001) begin
            n.en = 1'b0;
            n.dst = DST_IDLE;
          end else if (q.dbcnt == 9'h001) begin
            n.dst = DST_IDLE;
          end else begin
            n.dst = DST_GATHER;
          end
        end
      end
      default: n.dst = DST_IDLE;
    endcase
    // Software writes land after the hardware updates so a write wins a same-cycle decrement
    if (wr_ctrl) begin
      n.ctrl = sel_merge(q.ctrl, wb_dat_i, wb_sel_i) & `DBSC_CTRL_MASK;
    end
    if (wr_setup) begin
      n.flow = setup_wr[`DBSC_FLOW_HI:`DBSC_FLOW_LO];
      n.lock = setup_wr[`DBSC_LOCK_BIT];
      n.halt = setup_wr[`DBSC_HALT_BIT];
      n.en = 1'b0;
      // Reserved width codes keep the channel from starting
      if (setup_wr[`DBSC_EN_BIT] && sb != 3'h0 && db != 3'h0) begin
        n.en = 1'b1;
        if (!q.en) begin
          n.srem = 14'({2'b00, cnt} * 14'(db));
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ctrl <= `DBSC_CTRL_RST;
    end else if (ce_i) begin
      q <= n;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign src_rd_o = q.sst == SRC_READ;
  assign dst_wr_o = q.dst == DST_WRITE;
  assign dst_wdata_o = q.dbuf;
  assign src_size_o = q.ctrl[`DBSC_SWID_HI:`DBSC_SWID_LO];
  assign dst_size_o = q.ctrl[`DBSC_DWID_HI:`DBSC_DWID_LO];
  // Data access always; the other three attribute bits follow the protection field
  assign hprot_o = {q.ctrl[`DBSC_PROT_HI:`DBSC_PROT_LO], 1'b1};
  assign hlock_o = q.lock;
  // Bus bursts stay single beats; peripheral burst length only paces requests
  assign hburst_o = `DBSC_HBURST_SINGLE;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence src_burst_start;
    q.sst == SRC_IDLE ##1 q.sst == SRC_READ;
  endsequence
  sequence dst_burst_start;
    q.dst == DST_IDLE ##1 q.dst == DST_GATHER;
  endsequence

  src_burst_len_a: assert property (src_burst_start |-> q.sbcnt == burst_len($past(q.ctrl[14:12])))
    else $error("source burst length wrong");
  dst_burst_len_a: assert property (dst_burst_start |-> q.dbcnt == burst_len($past(q.ctrl[17:15])))
    else $error("destination burst length wrong");
  burst_table_a: assert property (src_burst_start ##0 $past(q.ctrl[14:12]) == 3'h7 |-> q.sbcnt == 9'h100)
    else $error("burst code seven not 256");
  hburst_fixed_a: assert property (hburst_o == 3'h0 && $stable(hburst_o))
    else $error("bus burst type changed");
  prot_map_a: assert property (hprot_o[3:1] == q.ctrl[30:28] && hprot_o[0])
    else $error("protection attributes wrong");
  count_load_a: assert property (wr_ctrl && wb_sel_i[1:0] == 2'h3 |=> cnt == $past(wb_dat_i[11:0]))
    else $error("count not loaded");
  count_dec_a: assert property (dst_wr_o && dst_ready_i && ctl_flow && !wr_ctrl |=> cnt == $past(cnt) - 12'h001)
    else $error("count did not decrement");
  count_stop_a: assert property (ctl_flow && cnt == '0 && q.dst == DST_IDLE |=> q.dst == DST_IDLE)
    else $error("transfer after count reached zero");
  width_ok_a: assert property ($rose(q.en) |-> sb != 3'h0 && db != 3'h0)
    else $error("enabled with reserved width");
  pack_full_a: assert property ($rose(dst_wr_o) |-> {1'b0, $past(q.didx)} == db - 3'h1)
    else $error("destination word not fully packed");
  // Source side must not outlive the descriptor either, or the queue would fill with stale bytes
  src_stop_a: assert property (ctl_flow && q.srem == '0 && q.sst == SRC_IDLE |=> q.sst == SRC_IDLE)
    else $error("source read after remaining bytes ran out");
  count_hold_a: assert property (!(dst_wr_o && dst_ready_i) && !wr_ctrl |=> cnt == $past(cnt))
    else $error("count moved without a destination transfer");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
endmodule
`default_nettype wire

// ===== include/dbsc_params.svh
// Register offsets, field positions, reset values and codes for the DMA burst/size control block
`ifndef DBSC_PARAMS_SVH
`define DBSC_PARAMS_SVH
`define DBSC_CTRL_OFS 8'h00
`define DBSC_SETUP_OFS 8'h04
`define DBSC_CTRL_RST 32'h0000_0000
`define DBSC_PROT_HI 30
`define DBSC_PROT_LO 28
`define DBSC_DWID_HI 23
`define DBSC_DWID_LO 21
`define DBSC_SWID_HI 20
`define DBSC_SWID_LO 18
`define DBSC_DBSZ_HI 17
`define DBSC_DBSZ_LO 15
`define DBSC_SBSZ_HI 14
`define DBSC_SBSZ_LO 12
`define DBSC_CNT_HI 11
`define DBSC_CNT_LO 0
`define DBSC_CTRL_MASK 32'h70ff_ffff
`define DBSC_EN_BIT 0
`define DBSC_FLOW_HI 13
`define DBSC_FLOW_LO 11
`define DBSC_LOCK_BIT 16
`define DBSC_ACT_BIT 17
`define DBSC_HALT_BIT 18
`define DBSC_FLOW_CTRL_MAX 3'h3
`define DBSC_HBURST_SINGLE 3'h0
`define DBSC_FIFO_WIDTH 8
`define DBSC_FIFO_DEPTH 32
`endif

// ===== include/dbsc_pkg.sv
// Types shared by the DMA burst/size control block
`default_nettype none
package dbsc_pkg;
  typedef enum logic [1:0] {SRC_IDLE, SRC_READ, SRC_PUSH} dbsc_src_e;
  typedef enum logic [1:0] {DST_IDLE, DST_GATHER, DST_WRITE} dbsc_dst_e;
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [31:0] ctrl;
    logic en;
    logic [2:0] flow;
    logic lock;
    logic halt;
    logic [1:0] req_s1;
    logic [1:0] req_s2;
    dbsc_src_e sst;
    logic [8:0] sbcnt;
    logic [13:0] srem;
    logic [31:0] sbuf;
    logic [1:0] sidx;
    dbsc_dst_e dst;
    logic [8:0] dbcnt;
    logic [31:0] dbuf;
    logic [1:0] didx;
  } dbsc_state_s;
endpackage
`default_nettype wire

// ===== verif/dbsc_far_model.sv
// Far side model: source memory and destination sink with random wait states
`timescale 1ns/10ps
`default_nettype none
module dbsc_far_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic src_rd_i,
  input wire logic [2:0] src_size_i,
  input wire logic dst_wr_i,
  output logic [31:0] src_rdata_o,
  output logic src_rvalid_o,
  output logic dst_ready_o
);
  logic [7:0] ptr;
  int src_beats;
  int dst_beats;
  // Inverse pattern between beats so a stale bus value never passes
  assign src_rdata_o = src_rvalid_o ? {ptr + 8'h3, ptr + 8'h2, ptr + 8'h1, ptr} : ~{ptr, ptr, ptr, ptr};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr <= 8'h0;
      src_rvalid_o <= 1'b0;
      dst_ready_o <= 1'b0;
      src_beats <= 0;
      dst_beats <= 0;
    end else begin
      src_rvalid_o <= src_rd_i && !src_rvalid_o && ($urandom_range(3) == 0);
      dst_ready_o <= dst_wr_i && !dst_ready_o && ($urandom_range(3) == 0);
      if (src_rvalid_o && src_rd_i) begin
        ptr <= ptr + (8'h1 << src_size_i);
        src_beats <= src_beats + 1;
      end
      if (dst_ready_o && dst_wr_i) begin
        dst_beats <= dst_beats + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the channel control block
`timescale 1ns/10ps
`default_nettype none
`include "dbsc_params.svh"
module tb;
  logic clk_i, rst_i, cyc, stb, we, sbr, dbr, src_rd, src_rv, dst_wr, dst_rdy, ack, lock;
  logic [7:0] adr, exp_ptr;
  logic [31:0] dat, rdat, src_dat, dst_dat, q, v, e;
  logic [2:0] ssz, dsz, hburst, sw, dw;
  logic [3:0] hprot, sel, wsel;
  int bad_count, n_compared, sb0, db0, cnt;

  dbsc_channel u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .src_breq_i(sbr),
    .dst_breq_i(dbr), .src_rd_o(src_rd), .src_rdata_i(src_dat), .src_rvalid_i(src_rv), .dst_wr_o(dst_wr),
    .dst_wdata_o(dst_dat), .dst_ready_i(dst_rdy), .src_size_o(ssz), .dst_size_o(dsz), .hprot_o(hprot),
    .hlock_o(lock), .hburst_o(hburst));
  dbsc_far_model u_far (.clk_i(clk_i), .rst_i(rst_i), .src_rd_i(src_rd), .src_size_i(ssz), .dst_wr_i(dst_wr),
    .src_rdata_o(src_dat), .src_rvalid_o(src_rv), .dst_ready_o(dst_rdy));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Classic single cycle; only the watchdog ends a wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= wsel;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  function automatic int blen(input int c);
    return c == 0 ? 1 : 2 << c;
  endfunction

  function automatic logic [31:0] sel_exp(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
    return {s[3] ? d[31:24] : o[31:24], s[2] ? d[23:16] : o[23:16], s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  function automatic logic [31:0] exp_word(input logic [7:0] p, input logic [2:0] s);
    logic [31:0] w;
    w = {p + 8'h3, p + 8'h2, p + 8'h1, p};
    return s == 3'h0 ? {24'h0, w[7:0]} : s == 3'h1 ? {16'h0, w[15:0]} : w;
  endfunction

  // Source bytes arrive in order, so each destination word follows a running byte pointer
  always @(posedge clk_i) begin
    if (rst_i) exp_ptr <= 8'h0;
    else if (dst_wr === 1'b1 && dst_rdy === 1'b1) begin
      chk("dst_wdata", dst_dat, exp_word(exp_ptr, dsz));
      chk("hburst_busy", {29'h0, hburst}, {29'h0, `DBSC_HBURST_SINGLE});
      exp_ptr <= exp_ptr + (8'h1 << dsz);
    end
  end

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    final_report();
  end

  initial begin
    void'($urandom(32'h613f));
    wsel = 4'hf;
    {rst_i, cyc, stb, we, sbr, dbr, adr, dat, sel} <= {6'b100000, 8'h0, 32'h0, 4'hf};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("hprot_rst", {28'h0, hprot}, 32'h1);
    wb(1'b0, `DBSC_CTRL_OFS, 32'h0);
    chk("ctrl_rst", q, `DBSC_CTRL_RST);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
    e = `DBSC_CTRL_RST;
    // Byte enables all set on the first pass and drawn at random after; only enabled bytes of the control word may change
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      wsel = i == 0 ? 4'hf : 4'($urandom);
      wb(1'b1, `DBSC_CTRL_OFS, v);
      e = sel_exp(e, v, wsel) & `DBSC_CTRL_MASK;
      wsel = 4'hf;
      wb(1'b0, `DBSC_CTRL_OFS, 32'h0);
      chk("ctrl_rw", q, e);
    end
    for (int p = 0; p < 8; p++) begin
      wb(1'b1, `DBSC_CTRL_OFS, (32'(p) << 28) | (32'(p) << 15) | (32'(p) << 12));
      wb(1'b1, `DBSC_SETUP_OFS, 32'(p & 1) << `DBSC_LOCK_BIT);
      repeat (3) @(posedge clk_i);
      chk("hprot", {28'h0, hprot}, {28'h0, p[2:0], 1'b1});
      chk("hburst", {29'h0, hburst}, 32'h0);
      chk("hlock", {31'h0, lock}, 32'(p & 1));
    end
    wb(1'b1, `DBSC_CTRL_OFS, (32'($urandom_range(7, 3)) << `DBSC_DWID_LO) | 32'h4);
    wb(1'b1, `DBSC_SETUP_OFS, 32'h1);
    wb(1'b0, `DBSC_SETUP_OFS, 32'h0);
    chk("en_reserved", {31'h0, q[0]}, 32'h0);
    // One request pulse on each side moves exactly one burst; odd passes hand flow to the peripheral
    for (int c = 0; c < 4; c++) begin
      sb0 = u_far.src_beats;
      db0 = u_far.dst_beats;
      v = c[0] ? 32'h0024_0000 : 32'h0024_0064;
      wb(1'b1, `DBSC_CTRL_OFS, (32'(c) << 15) | (32'(c) << 12) | v);
      wb(1'b1, `DBSC_SETUP_OFS, (c[0] ? 32'h4 << `DBSC_FLOW_LO : 32'h0) | 32'h1);
      sbr <= 1'b1;
      dbr <= 1'b1;
      @(posedge clk_i);
      sbr <= 1'b0;
      dbr <= 1'b0;
      repeat (500) @(posedge clk_i);
      chk("src_beats", 32'(u_far.src_beats - sb0), 32'(blen(c)));
      chk("dst_beats", 32'(u_far.dst_beats - db0), 32'(blen(c)));
      wb(1'b1, `DBSC_SETUP_OFS, 32'h0);
      wb(1'b0, `DBSC_CTRL_OFS, 32'h0);
      chk("count_left", {20'h0, q[11:0]}, 32'(c[0] ? 0 : 100 - blen(c)));
    end
    // Requests held high as for memory; the count alone ends the descriptor
    for (int r = 0; r < 3; r++) begin
      sw = r == 0 ? 3'h0 : 3'($urandom_range(2));
      dw = r == 0 ? 3'h2 : 3'($urandom_range(2));
      cnt = 4 * $urandom_range(3, 1);
      db0 = u_far.dst_beats;
      v = r == 0 ? 32'h7 << `DBSC_SBSZ_LO : 32'h0;
      wb(1'b1, `DBSC_CTRL_OFS, (32'(dw) << `DBSC_DWID_LO) | (32'(sw) << `DBSC_SWID_LO) | 32'(cnt) | v);
      wb(1'b1, `DBSC_SETUP_OFS, (32'($urandom_range(3)) << `DBSC_FLOW_LO) | 32'h1);
      sbr <= 1'b1;
      dbr <= 1'b1;
      repeat (900) @(posedge clk_i);
      sbr <= 1'b0;
      dbr <= 1'b0;
      chk("sizes", {26'h0, ssz, dsz}, {26'h0, sw, dw});
      chk("total_beats", 32'(u_far.dst_beats - db0), 32'(cnt));
      wb(1'b0, `DBSC_SETUP_OFS, 32'h0);
      chk("en_done", {31'h0, q[0]}, 32'h0);
      wb(1'b0, `DBSC_CTRL_OFS, 32'h0);
      chk("count_end", {20'h0, q[11:0]}, 32'h0);
    end
    final_report();
  end
endmodule
`default_nettype wire
